// ===== inc/cfg_msg_map.svh
// constants of the configuration message engine: token codes and field sizes
// assumes it is included by bare name from the design modules and the bench
`ifndef CFG_MSG_MAP_SVH
`define CFG_MSG_MAP_SVH

// ****************************************************************
// request opening tokens
// ****************************************************************
`define CFG_TOK_CFG_WR 8'hc0
`define CFG_TOK_CFG_RD 8'hc1
`define CFG_TOK_PER_WR 8'h24
`define CFG_TOK_PER_RD 8'h25

// ****************************************************************
// reply and closing tokens
// ****************************************************************
`define CFG_TOK_OK 8'h03
`define CFG_TOK_FAIL 8'h04
`define CFG_TOK_END 8'h01

// ****************************************************************
// field sizes and the reply-suppressing id byte
// ****************************************************************
`define CFG_RID_LAST 8'h02
`define CFG_CFG_REG_LAST 8'h01
`define CFG_WORD_LAST 8'h03
`define CFG_WORD_BYTES 3'h4
`define CFG_NOREPLY_LO 8'hff

`endif

// ===== inc/cfg_msg_pkg.sv
// types shared by the configuration message engine and its reply sender
// assumes the token constants of cfg_msg_map.svh are used alongside
package cfg_msg_pkg;

  // one token on the interconnect: control flag plus byte
  typedef struct packed {
    logic ctrl;
    logic [7:0] data;
  } tok_s;

  typedef enum logic [1:0] {
    SP_TILE = 2'b00,
    SP_NODE = 2'b01,
    SP_PERIPH = 2'b10
  } space_e;

  // register access handed to the register banks
  typedef struct packed {
    space_e space;
    logic wr;
    logic [15:0] addr;
    logic [7:0] size;
    logic [31:0] wdata;
  } reg_req_s;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RID = 3'b001,
    S_REGN = 3'b011,
    S_SIZE = 3'b010,
    S_DATA = 3'b110,
    S_END = 3'b111,
    S_ACC = 3'b101,
    S_SKIP = 3'b100
  } eng_st_e;

  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_HEAD = 2'b01,
    T_DATA = 2'b11,
    T_TAIL = 2'b10
  } tx_st_e;

endpackage

// ===== design/cfg_reply_tx.sv
// reply sender: emits ok/fail token, data bytes msb first, closing token
// assumes the sink may hold i_tx_ready low at any time
`timescale 1ns/1ps
`include "cfg_msg_map.svh"

module cfg_reply_tx
  import cfg_msg_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // reply order from the engine
  input wire logic i_start,
  input wire logic i_ok,
  input wire logic [2:0] i_nbytes,
  input wire logic [31:0] i_rdata,
  input wire logic [23:0] i_dest,
  output logic o_busy,
  // token stream out
  output tok_s o_tx,
  output logic o_tx_valid,
  output logic [23:0] o_tx_dest,
  input wire logic i_tx_ready
);

  typedef struct packed {
    tx_st_e st;
    logic [2:0] cnt;
    logic [31:0] sreg;
    logic valid;
    tok_s tok;
    logic [23:0] dest;
  } tx_s;

  tx_s q, d;

  // left-justify the low n bytes so the top byte leaves first
  function automatic logic [31:0] left_just(input logic [31:0] v,
                                            input logic [2:0] n);
    case (n)
      3'h1: left_just = {v[7:0], 24'h0};
      3'h2: left_just = {v[15:0], 16'h0};
      3'h3: left_just = {v[23:0], 8'h0};
      default: left_just = v;
    endcase
  endfunction

  always_comb begin
    d = q;
    case (q.st)
      T_IDLE: begin
        if (i_start) begin
          d.valid = 1'b1;
          d.tok.ctrl = 1'b1;
          d.tok.data = i_ok ? `CFG_TOK_OK : `CFG_TOK_FAIL;
          d.dest = i_dest;
          d.cnt = i_ok ? i_nbytes : 3'h0;
          d.sreg = left_just(i_rdata, i_nbytes);
          d.st = T_HEAD;
        end
      end
      T_HEAD, T_DATA: begin
        if (i_tx_ready) begin
          if (q.cnt != 3'h0) begin
            d.tok.ctrl = 1'b0;
            d.tok.data = q.sreg[31:24];
            d.sreg = {q.sreg[23:0], 8'h0};
            d.cnt = q.cnt - 3'h1;
            d.st = T_DATA;
          end else begin
            d.tok.ctrl = 1'b1;
            d.tok.data = `CFG_TOK_END;
            d.st = T_TAIL;
          end
        end
      end
      T_TAIL: begin
        if (i_tx_ready) begin
          d.valid = 1'b0;
          d.st = T_IDLE;
        end
      end
      default: d = '0;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_busy = (q.st != T_IDLE);
  assign o_tx = q.tok;
  assign o_tx_valid = q.valid;
  assign o_tx_dest = q.dest;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_ok_head;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!o_busy && i_start && i_ok) |=>
      (o_tx_valid && o_tx.ctrl && o_tx.data == 8'h03);
  endproperty
  a_ok_head: assert property (p_ok_head)
    else $error("success reply does not open with token 3");

  property p_fail_then_end;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!o_busy && i_start && !i_ok) ##1 i_tx_ready |->
      (o_tx_valid && o_tx.ctrl && o_tx.data == 8'h04) ##1
      (o_tx_valid && o_tx.ctrl && o_tx.data == 8'h01);
  endproperty
  a_fail_then_end: assert property (p_fail_then_end)
    else $error("failure reply is not token 4 then token 1");

  property p_hold;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (o_tx_valid && !i_tx_ready) |=>
      (o_tx_valid && $stable(o_tx) && $stable(o_tx_dest));
  endproperty
  a_hold: assert property (p_hold)
    else $error("reply token changed while stalled");

  property p_end_frees;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (o_tx_valid && i_tx_ready && o_tx.ctrl && o_tx.data == 8'h01) |=>
      (!o_busy && !o_tx_valid);
  endproperty
  a_end_frees: assert property (p_end_frees)
    else $error("sender still busy after closing token");

endmodule // cfg_reply_tx

// ===== design/cfg_msg_engine.sv
// configuration message engine: parses framed register requests arriving
// on a channel-end, drives one register access for each well-formed request, and replies unless the id is cut short or a write's id ends in ff
// assumes register banks answer every request with one i_reg_ack pulse
`timescale 1ns/1ps
`include "cfg_msg_map.svh"

module cfg_msg_engine
  import cfg_msg_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // request token stream in
  input tok_s i_rx,
  input wire logic i_rx_valid,
  output logic o_rx_ready,
  input wire logic i_ep_node,
  // reply token stream out
  output tok_s o_tx,
  output logic o_tx_valid,
  output logic [23:0] o_tx_dest,
  input wire logic i_tx_ready,
  // register bank access
  output reg_req_s o_reg,
  output logic o_reg_req,
  input wire logic i_reg_ack,
  input wire logic i_reg_ok,
  input wire logic [31:0] i_reg_rdata
);

  typedef struct packed {
    eng_st_e st;
    logic ready;
    logic [7:0] cnt;
    logic [23:0] rid;
    logic bad;
    logic req;
    reg_req_s r;
    logic start;
    logic ok;
    logic [2:0] nbytes;
    logic [31:0] rdata;
  } eng_s;

  eng_s q, d;
  logic take;
  logic tx_busy;

  function automatic logic listening(input eng_st_e s);
    listening = (s != S_ACC);
  endfunction

  assign take = i_rx_valid && q.ready;

  // ****************************************************************
  // request parser and access sequencer
  // ****************************************************************
  always_comb begin
    d = q;
    d.start = 1'b0;
    case (q.st)
      S_IDLE: begin
        if (take) begin
          d.cnt = 8'h0;
          d.rid = 24'h0;
          d.bad = 1'b0;
          d.r = '0;
          d.r.space = i_ep_node ? SP_NODE : SP_TILE;
          d.st = S_RID;
          if (!i_rx.ctrl) begin
            d.st = S_SKIP;
          end else begin
            case (i_rx.data)
              `CFG_TOK_CFG_WR: d.r.wr = 1'b1;
              `CFG_TOK_CFG_RD: d.r.wr = 1'b0;
              `CFG_TOK_PER_WR: begin
                d.r.wr = 1'b1;
                d.r.space = SP_PERIPH;
              end
              `CFG_TOK_PER_RD: d.r.space = SP_PERIPH;
              `CFG_TOK_END: d.st = S_IDLE;
              default: d.st = S_SKIP;
            endcase
          end
        end
      end
      S_RID, S_REGN, S_SIZE, S_DATA: begin
        if (take && i_rx.ctrl) begin
          // cut short: without a full id there is nowhere to answer
          if (q.st == S_RID) begin
            d.st = (i_rx.data == `CFG_TOK_END) ? S_IDLE : S_SKIP;
          end else begin
            d.bad = 1'b1;
            d.st = (i_rx.data == `CFG_TOK_END) ? S_ACC : S_END;
          end
        end else if (take) begin
          d.cnt = q.cnt + 8'h01;
          case (q.st)
            S_RID: begin
              d.rid = {q.rid[15:0], i_rx.data};
              if (q.cnt == `CFG_RID_LAST) begin
                d.cnt = 8'h0;
                d.st = S_REGN;
              end
            end
            S_REGN: begin
              d.r.addr = {q.r.addr[7:0], i_rx.data};
              if (q.r.space == SP_PERIPH) begin
                d.cnt = 8'h0;
                d.st = S_SIZE;
              end else if (q.cnt == `CFG_CFG_REG_LAST) begin
                d.cnt = 8'h0;
                d.r.size = 8'h04;
                d.st = q.r.wr ? S_DATA : S_END;
              end
            end
            S_SIZE: begin
              d.r.size = i_rx.data;
              d.cnt = 8'h0;
              // only one to four bytes fit the data word
              d.bad = (i_rx.data == 8'h0) || (i_rx.data > 8'h04);
              d.st = (q.r.wr && i_rx.data != 8'h0) ? S_DATA : S_END;
            end
            default: begin
              d.r.wdata = {q.r.wdata[23:0], i_rx.data};
              if ((q.r.space == SP_PERIPH) ? (d.cnt == q.r.size)
                                           : (q.cnt == `CFG_WORD_LAST)) begin
                d.st = S_END;
              end
            end
          endcase
        end
      end
      S_END: begin
        if (take) begin
          if (i_rx.ctrl && i_rx.data == `CFG_TOK_END) begin
            d.st = S_ACC;
            d.req = !q.bad;
          end else begin
            d.bad = 1'b1;
          end
        end
      end
      S_ACC: begin
        if (q.bad || i_reg_ack) begin
          d.req = 1'b0;
          d.ok = !q.bad && i_reg_ok;
          d.rdata = i_reg_rdata;
          d.nbytes = q.r.wr ? 3'h0 :
                     (q.r.space == SP_PERIPH) ? q.r.size[2:0]
                                              : `CFG_WORD_BYTES;
          d.start = !(q.r.wr && q.rid[7:0] == `CFG_NOREPLY_LO);
          d.st = S_IDLE;
        end
      end
      S_SKIP: begin
        if (take && i_rx.ctrl && i_rx.data == `CFG_TOK_END) begin
          d.st = S_IDLE;
        end
      end
      default: d.st = S_IDLE;
    endcase
    // no new token until the previous reply has fully left
    d.ready = listening(d.st) && !d.start && !q.start && !tx_busy;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_rx_ready = q.ready;
  assign o_reg = q.r;
  assign o_reg_req = q.req;

  // ****************************************************************
  // reply sender
  // ****************************************************************
  cfg_reply_tx u_reply (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_start(q.start),
    .i_ok(q.ok),
    .i_nbytes(q.nbytes),
    .i_rdata(q.rdata),
    .i_dest(q.rid),
    .o_busy(tx_busy),
    .o_tx(o_tx),
    .o_tx_valid(o_tx_valid),
    .o_tx_dest(o_tx_dest),
    .i_tx_ready(i_tx_ready)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_noreply;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (q.st == S_ACC && i_reg_ack && q.r.wr && q.rid[7:0] == 8'hff) |=>
      (!q.start ##1 !o_tx_valid);
  endproperty
  a_noreply: assert property (p_noreply)
    else $error("reply sent for a suppressed write");

  property p_read_reply;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (q.st == S_ACC && i_reg_ack && !q.r.wr) |=>
      (q.start ##1 (o_tx_valid && o_tx_dest == $past(q.rid, 2)));
  endproperty
  a_read_reply: assert property (p_read_reply)
    else $error("read not answered to its own channel-end");

  property p_req_hold;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (o_reg_req && !i_reg_ack) |=> (o_reg_req && $stable(o_reg));
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("register request dropped before ack");

  property p_busy_blocks;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    tx_busy |-> !o_rx_ready;
  endproperty
  a_busy_blocks: assert property (p_busy_blocks)
    else $error("request taken while a reply is pending");

  property p_open_cfg;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (q.st == S_IDLE && take && i_rx.ctrl && i_rx.data == 8'hc0) |=>
      (q.st == S_RID && q.r.wr && q.r.space != SP_PERIPH);
  endproperty
  a_open_cfg: assert property (p_open_cfg)
    else $error("config write opening token not recognised");

  property p_open_per;
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (q.st == S_IDLE && take && i_rx.ctrl && i_rx.data == 8'h25) |=>
      (q.st == S_RID && !q.r.wr && q.r.space == SP_PERIPH);
  endproperty
  a_open_per: assert property (p_open_per)
    else $error("peripheral read opening token not recognised");

endmodule // cfg_msg_engine

// ===== sim/cfg_bank_model.sv
// register bank stand-in: answers each access after a chosen delay
// assumes one outstanding access, held until the ack pulse
`timescale 1ns/1ps
module cfg_bank_model
  import cfg_msg_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // access from the engine
  input reg_req_s i_reg,
  input wire logic i_reg_req,
  // behaviour set by the bench
  input wire logic [3:0] i_delay,
  input wire logic i_fail,
  input wire logic [31:0] i_value,
  // answer
  output logic o_ack,
  output logic o_ok,
  output logic [31:0] o_rdata
);
  logic [3:0] wait_q;
  logic done_q;
  logic [31:0] junk_q;
  logic [31:0] keep;

  // outside the ack cycle, and above the asked size, lines carry junk
  assign keep = (i_reg.size > 8'h03) ? 32'hffff_ffff
              : ((32'h1 << {i_reg.size[1:0], 3'h0}) - 32'h1);
  assign o_ack = i_reg_req && !done_q && (wait_q == i_delay);
  assign o_ok = o_ack ? !i_fail : junk_q[0];
  assign o_rdata = o_ack ? ((i_value & keep) | (junk_q & ~keep)) : junk_q;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_q <= 4'h0;
      done_q <= 1'b0;
      junk_q <= 32'h5a5a_c3c3;
    end else begin
      junk_q <= ~junk_q;
      if (!i_reg_req) begin
        wait_q <= 4'h0;
        done_q <= 1'b0;
      end else if (o_ack)
        done_q <= 1'b1;
      else
        wait_q <= wait_q + 4'h1;
    end
  end
endmodule // cfg_bank_model

// ===== sim/config_register_access_messages_bench.sv
// bench: plays the requesting channel-end, checks replies and accesses
// assumes cfg_msg_engine and cfg_bank_model
`timescale 1ns/1ps
`include "cfg_msg_map.svh"
module config_register_access_messages_bench
  import cfg_msg_pkg::*;
;
  logic i_core_clk, i_rst_b, i_rx_valid, o_rx_ready, i_ep_node, o_tx_valid;
  logic i_tx_ready, o_reg_req, i_reg_ack, i_reg_ok, stall, bank_fail;
  logic [3:0] bank_delay;
  logic [31:0] i_reg_rdata, bank_value;
  logic [23:0] o_tx_dest;
  tok_s i_rx, o_tx;
  reg_req_s o_reg, seen_reg;
  logic [8:0] msg_q[$];
  logic [32:0] got_q[$];
  int err_count, n_tests, reg_count, want;

  cfg_msg_engine dut (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_rx(i_rx),
    .i_rx_valid(i_rx_valid), .o_rx_ready(o_rx_ready), .i_ep_node(i_ep_node),
    .o_tx(o_tx), .o_tx_valid(o_tx_valid), .o_tx_dest(o_tx_dest),
    .i_tx_ready(i_tx_ready), .o_reg(o_reg), .o_reg_req(o_reg_req),
    .i_reg_ack(i_reg_ack), .i_reg_ok(i_reg_ok), .i_reg_rdata(i_reg_rdata)
  );
  cfg_bank_model bank (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_reg(o_reg),
    .i_reg_req(o_reg_req), .i_delay(bank_delay), .i_fail(bank_fail),
    .i_value(bank_value), .o_ack(i_reg_ack), .o_ok(i_reg_ok),
    .o_rdata(i_reg_rdata)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // ****************************************************************
  // monitors: reply sink with optional stalls, access recorder
  // ****************************************************************
  always @(posedge i_core_clk) begin
    if (o_tx_valid && i_tx_ready)
      got_q.push_back({o_tx_dest, o_tx});
    if (o_reg_req && i_reg_ack) begin
      seen_reg = o_reg;
      reg_count++;
    end
    i_tx_ready <= stall ? ~i_tx_ready : 1'b1;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic give_up();
    err_count++;
    finish_test();
  endtask

  task automatic add(input logic c, input logic [31:0] v, input int n);
    for (int k = n - 1; k >= 0; k--)
      msg_q.push_back({c, v[8*k +: 8]});
  endtask

  task automatic build(input logic [7:0] op, input logic [23:0] rid,
                       input logic [7:0] rn, input logic [7:0] size,
                       input logic [31:0] data, input int nd);
    add(1'b1, {24'h0, op}, 1);
    add(1'b0, {8'h0, rid}, 3);
    add(1'b0, {16'h0, size, rn}, op[7] ? 2 : 1);
    if (!op[7])
      add(1'b0, {24'h0, size}, 1);
    add(1'b0, data, nd);
    add(1'b1, {24'h0, `CFG_TOK_END}, 1);
  endtask

  // tokens are held until taken; ready is looked at where it is settled
  task automatic send_msg();
    int n;
    foreach (msg_q[k]) begin
      i_rx <= tok_s'(msg_q[k]);
      i_rx_valid <= 1'b1;
      n = 0;
      @(negedge i_core_clk);
      while (o_rx_ready !== 1'b1) begin
        n++;
        if (n > 300)
          give_up();
        @(negedge i_core_clk);
      end
      @(posedge i_core_clk);
    end
    i_rx_valid <= 1'b0;
    msg_q.delete();
    // let one edge pass so a following message never re-raises valid at once
    @(posedge i_core_clk);
  endtask

  task automatic expect_reply(input logic [23:0] rid, input logic ok,
                              input logic [31:0] data, input int nd);
    int n;
    add(1'b1, {24'h0, ok ? `CFG_TOK_OK : `CFG_TOK_FAIL}, 1);
    add(1'b0, data, nd);
    add(1'b1, {24'h0, `CFG_TOK_END}, 1);
    n = 0;
    while (got_q.size() < msg_q.size()) begin
      n++;
      if (n > 300)
        give_up();
      @(posedge i_core_clk);
    end
    foreach (msg_q[k])
      check(64'(got_q.pop_front()), 64'({rid, msg_q[k]}));
    msg_q.delete();
  endtask

  task automatic check_reg(input reg_req_s e);
    want++;
    check(64'(reg_count), 64'(want));
    check(64'({seen_reg.space, seen_reg.wr}), 64'({e.space, e.wr}));
    check(64'(seen_reg.size), 64'(e.size));
    check(64'(seen_reg.addr), 64'(e.addr));
    if (e.wr)
      check(64'(seen_reg.wdata), 64'(e.wdata));
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_cfg_write(input logic node, input logic fail);
    i_ep_node <= node;
    bank_fail <= fail;
    bank_delay <= fail ? 4'h9 : 4'h0;
    build(`CFG_TOK_CFG_WR, 24'h123456, 8'hef, 8'hbe, 32'hcafe_f00d, 4);
    send_msg();
    expect_reply(24'h123456, !fail, 32'h0, 0);
    check_reg('{node ? SP_NODE : SP_TILE, 1'b1, 16'hbeef, 8'h04,
                32'hcafe_f00d});
  endtask

  task automatic t_cfg_read(input logic fail, input logic [23:0] rid);
    i_ep_node <= 1'b1;
    stall <= 1'b1;
    bank_fail <= fail;
    bank_delay <= 4'h3;
    bank_value <= 32'h89ab_cdef;
    build(`CFG_TOK_CFG_RD, rid, 8'h02, 8'h01, 32'h0, 0);
    send_msg();
    expect_reply(rid, !fail, 32'h89ab_cdef, fail ? 0 : 4);
    check_reg('{SP_NODE, 1'b0, 16'h0102, 8'h04, 32'h0});
    stall <= 1'b0;
  endtask

  task automatic t_no_reply(input logic fail);
    i_ep_node <= 1'b0;
    bank_fail <= fail;
    bank_delay <= 4'h1;
    build(`CFG_TOK_CFG_WR, 24'h7654ff, 8'h10, 8'h00, 32'h0000_0001, 4);
    send_msg();
    repeat (30) @(posedge i_core_clk);
    check(64'(got_q.size()), 64'h0);
    check_reg('{SP_TILE, 1'b1, 16'h0010, 8'h04, 32'h1});
  endtask

  task automatic t_periph();
    bank_fail <= 1'b0;
    bank_delay <= 4'h2;
    bank_value <= 32'hffab_cdef;
    build(`CFG_TOK_PER_WR, 24'h000102, 8'h42, 8'h02, 32'h1234, 2);
    send_msg();
    expect_reply(24'h000102, 1'b1, 32'h0, 0);
    check_reg('{SP_PERIPH, 1'b1, 16'h0042, 8'h02, 32'h1234});
    build(`CFG_TOK_PER_RD, 24'h000103, 8'h43, 8'h03, 32'h0, 0);
    send_msg();
    expect_reply(24'h000103, 1'b1, 32'hab_cdef, 3);
    check_reg('{SP_PERIPH, 1'b0, 16'h0043, 8'h03, 32'h0});
    build(`CFG_TOK_PER_RD, 24'h000104, 8'h44, 8'h05, 32'h0, 0);
    send_msg();
    expect_reply(24'h000104, 1'b0, 32'h0, 0);
    check(64'(reg_count), 64'(want));
  endtask

  // a write cut short after two of its four data bytes fails with no access; stray data is dropped
  task automatic t_bad_frame();
    build(`CFG_TOK_CFG_WR, 24'h000105, 8'h01, 8'h00, 32'h0000_1234, 2);
    send_msg();
    expect_reply(24'h000105, 1'b0, 32'h0, 0);
    check(64'(reg_count), 64'(want));
    add(1'b0, 32'h55, 1);
    add(1'b1, {24'h0, `CFG_TOK_END}, 1);
    send_msg();
    repeat (10) @(posedge i_core_clk);
    check(64'(got_q.size()), 64'h0);
    check(64'(reg_count), 64'(want));
  endtask

  // second request waits while the first is served; replies keep order
  task automatic t_back_to_back();
    i_ep_node <= 1'b1;
    stall <= 1'b1;
    bank_fail <= 1'b0;
    bank_delay <= 4'h7;
    build(`CFG_TOK_CFG_WR, 24'h0000aa, 8'h01, 8'h00, 32'h11, 4);
    send_msg();
    build(`CFG_TOK_CFG_WR, 24'h0000bb, 8'h02, 8'h00, 32'h22, 4);
    send_msg();
    expect_reply(24'h0000aa, 1'b1, 32'h0, 0);
    expect_reply(24'h0000bb, 1'b1, 32'h0, 0);
    want++;
    check_reg('{SP_NODE, 1'b1, 16'h0002, 8'h04, 32'h22});
    stall <= 1'b0;
  endtask

  initial begin
    i_rst_b = 1'b0;
    i_rx = '0;
    i_rx_valid = 1'b0;
    i_ep_node = 1'b0;
    stall = 1'b0;
    bank_fail = 1'b0;
    bank_delay = 4'h0;
    bank_value = 32'h0;
    {err_count, n_tests, reg_count, want} = '0;
    repeat (20) @(posedge i_core_clk);
    check(64'({o_rx_ready, o_tx_valid, o_reg_req}), 64'h0);
    i_rst_b <= 1'b1;
    @(posedge i_core_clk);
    t_cfg_write(1'b0, 1'b0);
    t_cfg_write(1'b1, 1'b1);
    t_cfg_read(1'b0, 24'h0a0b0c);
    t_cfg_read(1'b1, 24'h0a0b0c);
    t_no_reply(1'b0);
    t_no_reply(1'b1);
    t_cfg_read(1'b0, 24'h0a0bff);
    t_periph();
    t_bad_frame();
    t_back_to_back();
    repeat (20) @(posedge i_core_clk);
    check(64'(got_q.size()), 64'h0);
    finish_test();
  end
endmodule // config_register_access_messages_bench
